// ---- hw/pmcap_regs_top.sv ----
// power management capability register set in configuration space
`timescale 1ns/1ps
`include "pmcap_regs.svh"
//
// Overview of operation
// - capability bit 15 follows cold wake config
// - wake state mask reads 1111b
// - deep doze support bit hardwired one
// - light doze support bit hardwired one
// - aux current 000b unless cold support, 001b
// - device specific init bit reads zero
// - reserved capability bit 4 reads zero
// - wake needs bus clock bit reads zero
// - spec revision field reads 010b
// - function reset leaves control/status untouched
// - wake status flag readable, host clears it
// - data scale and select bits read zero
// - wake signal enable gates wake signalling
// - control/status bits 7 to 2 zero
// - host writes power state, device reports it
// - power state changes on every field write
// - status, enable, state reset only by global reset
// - bridge extension and data bytes read zero
//
module pmcap_regs_top #(
   parameter int DW_ADDR_W = 6
) (
   // clock and global reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   // configuration access, one dword per request
   input  wire logic                 cfg_req,
   input  wire logic                 cfg_we,
   input  wire logic [DW_ADDR_W-1:0] cfg_dw_addr,
   input  wire logic [3:0]           cfg_be,
   input  wire logic [31:0]          cfg_wdata,
   output logic      [31:0]          cfg_rdata,
   output logic                      cfg_ack,
   // side inputs
   input  wire logic                 cold_wake_config_bit,
   input  wire logic                 wake_event,
   // function controls
   output logic      [1:0]           power_state_field,
   output logic                      fn_reset_pulse,
   output logic                      wake_request,
   output logic                      cold_state_wake_support
);

   localparam logic [7:0] CAP_OFF = `PMCAP_OFF_CAP;
   localparam logic [7:0] CSR_OFF = `PMCAP_OFF_CSR;
   localparam logic [DW_ADDR_W-1:0] CAP_DW = DW_ADDR_W'(CAP_OFF[7:2]);
   localparam logic [DW_ADDR_W-1:0] CSR_DW = DW_ADDR_W'(CSR_OFF[7:2]);

   logic        hit_cap;
   logic        hit_csr;
   logic        csr_wr;
   logic        ps_wr;
   logic        en_wr;
   logic        stat_clr;
   logic        wake_signal_enable_r;
   logic        wake_status_flag;
   logic [2:0]  aux_current;
   logic [15:0] cap_word;
   logic [15:0] csr_word;
   logic [31:0] rdata_nxt;
   logic        rd_cap_q;
   logic        rd_csr_q;

   // address decode and write strobes
   assign hit_cap  = cfg_req && (cfg_dw_addr == CAP_DW);
   assign hit_csr  = cfg_req && (cfg_dw_addr == CSR_DW);
   assign csr_wr   = hit_csr && cfg_we;
   assign ps_wr    = csr_wr && cfg_be[0];
   assign en_wr    = csr_wr && cfg_be[1];
   assign stat_clr = en_wr && cfg_wdata[`PMCAP_CSR_STAT_BIT];

   // cold wake support follows the config bit
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cold_state_wake_support <= 1'b0;
      end else begin
         cold_state_wake_support <= cold_wake_config_bit;
      end
   end

   // wake enable, global reset only
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_signal_enable_r <= 1'b0;
      end else if (en_wr) begin
         wake_signal_enable_r <= cfg_wdata[`PMCAP_CSR_EN_BIT];
      end
   end

   // wake status flag, write one to clear
   pmcap_sticky_flag u_wake_stat (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .set_evt (wake_event),
      .clr_evt (stat_clr),
      .flag_r  (wake_status_flag)
   );

   // power state and function reset pulse
   pmcap_pstate_ctl u_pstate (
      .ref_clk    (ref_clk),
      .rst_b      (rst_b),
      .wr_en      (ps_wr),
      .wr_val     (cfg_wdata[`PMCAP_CSR_PS_HI:`PMCAP_CSR_PS_LO]),
      .state_r    (power_state_field),
      .fn_reset_r (fn_reset_pulse)
   );

   // wake signalling gated by enable
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_request <= 1'b0;
      end else begin
         wake_request <= wake_status_flag && wake_signal_enable_r;
      end
   end

   // capabilities word, read-only, bit 15 and aux current follow cold support
   assign aux_current = cold_state_wake_support ? `PMCAP_AUX_55MA : `PMCAP_AUX_SELF;
   always_comb begin
      cap_word = 16'h0000;
      cap_word[`PMCAP_CAP_COLD_BIT] = cold_state_wake_support;
      cap_word[`PMCAP_CAP_MASK_HI:`PMCAP_CAP_MASK_LO] = `PMCAP_WAKE_STATE_MASK;
      cap_word[`PMCAP_CAP_D2_BIT] = 1'b1;
      cap_word[`PMCAP_CAP_D1_BIT] = 1'b1;
      cap_word[`PMCAP_CAP_AUX_HI:`PMCAP_CAP_AUX_LO] = aux_current;
      cap_word[`PMCAP_CAP_REV_HI:`PMCAP_CAP_REV_LO] = `PMCAP_SPEC_REV;
   end

   // control/status word, unused fields zero
   always_comb begin
      csr_word = 16'h0000;
      csr_word[`PMCAP_CSR_STAT_BIT] = wake_status_flag;
      csr_word[`PMCAP_CSR_EN_BIT] = wake_signal_enable_r;
      csr_word[`PMCAP_CSR_PS_HI:`PMCAP_CSR_PS_LO] = power_state_field;
   end

   // read mux, other dwords answer zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_cap) begin
         rdata_nxt = {cap_word, 16'h0000};
      end else if (hit_csr) begin
         rdata_nxt = {`PMCAP_DATA_RESET, `PMCAP_BSE_RESET, csr_word};
      end
   end

   // registered answer one cycle after request
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ack   <= 1'b0;
         cfg_rdata <= 32'h0000_0000;
      end else begin
         cfg_ack   <= cfg_req;
         cfg_rdata <= (cfg_req && !cfg_we) ? rdata_nxt : 32'h0000_0000;
      end
   end

   // what the current answer holds
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_cap_q <= 1'b0;
         rd_csr_q <= 1'b0;
      end else begin
         rd_cap_q <= hit_cap && !cfg_we;
         rd_csr_q <= hit_csr && !cfg_we;
      end
   end

   // checks on the register behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_cold_follow: assert property (rd_cap_q |-> cfg_rdata[31] == $past(cold_wake_config_bit, 2))
      else $error("cold support bit does not follow config bit");
   a_wake_mask: assert property (rd_cap_q |-> cfg_rdata[30:27] == 4'hF)
      else $error("wake state mask not 1111b");
   a_deep_doze: assert property (rd_cap_q |-> cfg_rdata[26])
      else $error("deep doze support bit not one");
   a_light_doze: assert property (rd_cap_q |-> cfg_rdata[25])
      else $error("light doze support bit not one");
   a_aux_current: assert property (rd_cap_q |-> cfg_rdata[24:22] == {2'h0, cfg_rdata[31]})
      else $error("aux current field wrong for cold support");
   a_init_bit: assert property (rd_cap_q |-> !cfg_rdata[21])
      else $error("device specific init bit set");
   a_cap_rsvd: assert property (rd_cap_q |-> !cfg_rdata[20])
      else $error("reserved capability bit set");
   a_clock_bit: assert property (rd_cap_q |-> !cfg_rdata[19])
      else $error("wake clock bit set");
   a_spec_rev: assert property (rd_cap_q |-> cfg_rdata[18:16] == 3'h2)
      else $error("spec revision field not 010b");
   a_fnrst_keep: assert property (fn_reset_pulse && !csr_wr |=>
                                  $stable(wake_signal_enable_r) && $stable(power_state_field))
      else $error("function reset changed control/status");
   a_stat_clear: assert property (stat_clr && !wake_event |=> !wake_status_flag)
      else $error("wake status not cleared");
   a_stat_set: assert property (wake_event |=> wake_status_flag ##1 wake_status_flag || $past(stat_clr))
      else $error("wake event lost");
   a_data_zero: assert property (rd_csr_q |-> cfg_rdata[14:9] == 6'h00)
      else $error("data scale or select not zero");
   a_wake_gate: assert property (wake_request |-> $past(wake_status_flag) && $past(wake_signal_enable_r))
      else $error("wake request without enable and status");
   a_csr_rsvd: assert property (rd_csr_q |-> cfg_rdata[7:2] == 6'h00)
      else $error("control/status reserved bits set");
   a_state_read: assert property (rd_csr_q |-> cfg_rdata[1:0] == $past(power_state_field))
      else $error("read power state differs from state");
   a_state_write: assert property (ps_wr |=> power_state_field == $past(cfg_wdata[1:0]))
      else $error("power state not taken from write");
   a_global_clear: assert property (disable iff (1'b0) !rst_b |->
                                    power_state_field == 2'h0 && !wake_status_flag && !wake_signal_enable_r)
      else $error("control/status not cleared by global reset");
   a_ext_bytes: assert property (rd_csr_q |-> cfg_rdata[31:16] == 16'h0000)
      else $error("bridge extension or data byte not zero");
   a_ro_write: assert property (hit_cap && cfg_we |=> $stable(power_state_field) &&
                                cold_state_wake_support == $past(cold_wake_config_bit))
      else $error("write to capabilities changed state");

   c_cold_read: cover property (rd_cap_q && cfg_rdata[31]);
   c_wake_req: cover property (wake_event ##1 wake_signal_enable_r ##1 wake_request);
   c_leave_d3hot: cover property (fn_reset_pulse);
   c_set_clear: cover property (wake_event && stat_clr);

endmodule

// ---- hw/pmcap_regs.svh ----
// offsets, field positions, reset values and fixed field codes of the power management capability
`ifndef PMCAP_REGS_SVH
`define PMCAP_REGS_SVH

// byte offsets in configuration space
`define PMCAP_OFF_CAP          8'h46
`define PMCAP_OFF_CSR          8'h48
`define PMCAP_OFF_BSE          8'h4A
`define PMCAP_OFF_DATA         8'h4B

// capabilities word field positions
`define PMCAP_CAP_COLD_BIT     15
`define PMCAP_CAP_MASK_HI      14
`define PMCAP_CAP_MASK_LO      11
`define PMCAP_CAP_D2_BIT       10
`define PMCAP_CAP_D1_BIT       9
`define PMCAP_CAP_AUX_HI       8
`define PMCAP_CAP_AUX_LO       6
`define PMCAP_CAP_DSI_BIT      5
`define PMCAP_CAP_RSVD_BIT     4
`define PMCAP_CAP_CLK_BIT      3
`define PMCAP_CAP_REV_HI       2
`define PMCAP_CAP_REV_LO       0

// control/status word field positions
`define PMCAP_CSR_STAT_BIT     15
`define PMCAP_CSR_EN_BIT       8
`define PMCAP_CSR_PS_HI        1
`define PMCAP_CSR_PS_LO        0

// fixed field codes
`define PMCAP_WAKE_STATE_MASK  4'hF
`define PMCAP_AUX_SELF         3'h0
`define PMCAP_AUX_55MA         3'h1
`define PMCAP_SPEC_REV         3'h2

// reset values
`define PMCAP_CAP_RESET        16'h7E02
`define PMCAP_CSR_RESET        16'h0000
`define PMCAP_BSE_RESET        8'h00
`define PMCAP_DATA_RESET       8'h00

`endif

// ---- hw/pmcap_pkg.sv ----
// types shared by the power management capability files
package pmcap_pkg;

   // power state codes, in field order
   typedef enum logic [1:0] {
      PMCAP_D0,
      PMCAP_D1,
      PMCAP_D2,
      PMCAP_D3HOT
   } pmcap_pstate_t;

endpackage

// ---- hw/pmcap_sticky_flag.sv ----
// sticky status flag, set by hardware, cleared by software, set wins
`timescale 1ns/1ps
module pmcap_sticky_flag (
   // clock and global reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // set and clear requests
   input  wire logic set_evt,
   input  wire logic clr_evt,
   // flag state
   output logic      flag_r
);

   // set beats a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= 1'b0;
      end else if (set_evt) begin
         flag_r <= 1'b1;
      end else if (clr_evt) begin
         flag_r <= 1'b0;
      end
   end

endmodule

// ---- hw/pmcap_pstate_ctl.sv ----
// power state holder with the leave-d3hot function reset pulse
`timescale 1ns/1ps
module pmcap_pstate_ctl (
   // clock and global reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // state write from configuration
   input  wire logic       wr_en,
   input  wire logic [1:0] wr_val,
   // state and reset pulse
   output logic [1:0]      state_r,
   output logic            fn_reset_r
);

   pmcap_pkg::pmcap_pstate_t cur_r;
   pmcap_pkg::pmcap_pstate_t cur_nxt;

   // new state on every write of the field
   always_comb begin
      cur_nxt = cur_r;
      if (wr_en) begin
         cur_nxt = pmcap_pkg::pmcap_pstate_t'(wr_val);
      end
   end

   // state register, cleared by the global reset only
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_r <= pmcap_pkg::PMCAP_D0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // mirror of the state as a plain field
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= 2'h0;
      end else begin
         state_r <= cur_nxt;
      end
   end

   // one-cycle function reset on d3hot to d0
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fn_reset_r <= 1'b0;
      end else begin
         fn_reset_r <= wr_en && (cur_r == pmcap_pkg::PMCAP_D3HOT) && (wr_val == 2'h0);
      end
   end

endmodule

// ---- sim/pmcap_host_model.sv ----
// host bridge and configuration software model driving the config port
`timescale 1ns/1ps
module pmcap_host_model (
   // clock
   input  wire logic  ref_clk,
   // configuration access
   output logic        cfg_req,
   output logic        cfg_we,
   output logic [5:0]  cfg_dw_addr,
   output logic [3:0]  cfg_be,
   output logic [31:0] cfg_wdata,
   // side controls from the general control register and wake source
   output logic        cold_wake_config_bit,
   output logic        wake_event
);
   // idle levels at time zero
   initial begin
      cfg_req = 1'b0;
      cfg_we = 1'b0;
      cfg_dw_addr = 6'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0;
      cold_wake_config_bit = 1'b0;
      wake_event = 1'b0;
   end

   // one access, held across the single taking edge
   task automatic access(input logic we, input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge ref_clk);
      cfg_req = 1'b1;
      cfg_we = we;
      cfg_dw_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge ref_clk);
      cfg_req = 1'b0;
      cfg_be = ~be; // released qualifiers show no stale value
      cfg_wdata = ~d;
      cfg_dw_addr = ~a;
   endtask

   // software setting of the cold wake configuration bit
   task automatic set_cold(input logic v);
      @(negedge ref_clk);
      cold_wake_config_bit = v;
   endtask

   // one-cycle wake event
   task automatic pulse_wake;
      @(negedge ref_clk);
      wake_event = 1'b1;
      @(negedge ref_clk);
      wake_event = 1'b0;
   endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the power management capability registers
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk;
   logic        rst_b;
   logic        cfg_req;
   logic        cfg_we;
   logic [5:0]  cfg_dw_addr;
   logic [3:0]  cfg_be;
   logic [31:0] cfg_wdata;
   logic [31:0] cfg_rdata;
   logic        cfg_ack;
   logic        cold_wake_config_bit;
   logic        wake_event;
   logic [1:0]  power_state_field;
   logic        fn_reset_pulse;
   logic        wake_request;
   logic        cold_state_wake_support;
   logic [31:0] exp_q[$];
   logic [31:0] rv;
   logic [1:0]  st;
   logic        en;
   logic        stat;
   logic        cold;
   int          failures;
   int          checks;
   int          pulses;
   int          seed;

   pmcap_regs_top #(.DW_ADDR_W(6)) u_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_dw_addr(cfg_dw_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .cold_wake_config_bit(cold_wake_config_bit), .wake_event(wake_event),
      .power_state_field(power_state_field), .fn_reset_pulse(fn_reset_pulse),
      .wake_request(wake_request), .cold_state_wake_support(cold_state_wake_support));

   pmcap_host_model u_host (
      .ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cold_wake_config_bit(cold_wake_config_bit), .wake_event(wake_event));

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // expected register words from the bench's own state
   function automatic logic [15:0] cap();
      return {cold, 4'hF, 2'h3, 2'h0, cold, 3'h0, 3'h2};
   endfunction
   function automatic logic [31:0] csr();
      return {16'h0000, stat, 6'h00, en, 6'h00, st};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // read, noting the expected word first
   task automatic rd(input logic [5:0] a);
      exp_q.push_back(a == 6'h11 ? {cap(), 16'h0000} : (a == 6'h12 ? csr() : 32'h0));
      u_host.access(1'b0, a, 4'hF, 32'h0);
   endtask

   // write, tracking the fields it should change
   task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
      exp_q.push_back(32'h0);
      if (a == 6'h12 && be[0]) st = d[1:0];
      if (a == 6'h12 && be[1]) begin
         en = d[8];
         if (d[15]) stat = 1'b0;
      end
      u_host.access(1'b1, a, be, d);
   endtask

   task automatic do_reset;
      @(negedge ref_clk);
      rst_b = 1'b0;
      st = 2'h0;
      en = 1'b0;
      stat = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
   endtask

   // answer watcher: oldest note against each acknowledged word
   always @(negedge ref_clk) begin
      if (cfg_ack === 1'b1) begin
         if (exp_q.size() == 0) check(cfg_rdata, 32'hFFFFFFFF);
         else check(cfg_rdata, exp_q.pop_front());
      end
      if (fn_reset_pulse === 1'b1) pulses++;
   end

   // watchdog
   initial begin
      #200000;
      failures++;
      results();
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      seed = 32'h585841F6;
      {st, en, stat, cold} = 5'h00;
      {failures, checks, pulses} = 0;
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      rd(6'h11);
      rd(6'h12);
      rd(6'h10);
      u_host.set_cold(1'b1);
      cold = 1'b1;
      repeat (3) @(negedge ref_clk);
      check({31'h0, cold_state_wake_support}, 32'h1);
      rd(6'h11);
      wr(6'h11, 4'hF, 32'hFFFFFFFF);
      rd(6'h11);
      wr(6'h12, 4'hF, 32'hFFFFFFFF);
      rd(6'h12);
      for (int i = 0; i < 4; i++) begin
         wr(6'h12, 4'h1, i);
         check({30'h0, power_state_field}, i);
         rd(6'h12);
      end
      pulses = 0;
      wr(6'h12, 4'h1, 32'h0);
      @(negedge ref_clk);
      check(pulses, 32'h1);
      rd(6'h12);
      u_host.pulse_wake();
      stat = 1'b1;
      repeat (2) @(negedge ref_clk);
      check({31'h0, wake_request}, 32'h1);
      rd(6'h12);
      wr(6'h12, 4'h2, 32'h8000);
      rd(6'h12);
      u_host.pulse_wake();
      stat = 1'b1;
      repeat (2) @(negedge ref_clk);
      check({31'h0, wake_request}, 32'h0);
      rd(6'h12);
      // wake event and host clear in one cycle: the set wins
      fork
         u_host.pulse_wake();
         wr(6'h12, 4'h2, 32'h8000);
      join
      stat = 1'b1;
      rd(6'h12);
      for (int i = 0; i < 40; i++) begin
         rv = $random(seed);
         wr(6'h12, rv[3:0], {rv[31:16] & 16'h81FF, rv[15:0] & 16'h7FFF});
         rd(6'h12);
         rd(rv[21:16]);
      end
      wr(6'h12, 4'h3, 32'h0102);
      do_reset();
      rd(6'h12);
      rd(6'h11);
      repeat (2) @(negedge ref_clk);
      check(exp_q.size(), 32'h0);
      results();
   end
endmodule
